/* File: hostport_defines.vh */
/*
  Constants for the host port wait-state controller: wait counts,
  penalties, protocol trap codes and register group address decode.
  Assumes inclusion by its bare name from the design modules.
*/
`ifndef HOSTPORT_DEFINES_VH
`define HOSTPORT_DEFINES_VH

`define WR_WAIT_TYP        4'h0
`define WR_WAIT_MAX        4'h3
`define RD_WAIT_TYP        4'h2
`define RD_WAIT_MAX        4'h5
`define RD_WAIT_ISP        4'h3
`define RD_WAIT_STILL      4'h5
`define RD_WAIT_VIDEO      4'h5
`define RD_WAIT_VIDEO_1ST  4'h7
`define RD_WAIT_3D         4'h7
`define PEN_WR_WR          4'h1
`define PEN_RD_RD          4'h1
`define PEN_WR_AFTER_RD    4'h1
`define PEN_RD_AFTER_WR    4'h3
`define DATA_HOLD_CYC      4'h1

`define GROUP_MSB          23
`define GROUP_LSB          20
`define GROUP_ISP          4'h1
`define GROUP_STILL        4'h2
`define GROUP_VIDEO        4'h3
`define GROUP_3D           4'h4

`define PROTO_DIRECT_80_1  3'h0
`define PROTO_DIRECT_80_2  3'h1
`define PROTO_DIRECT_68    3'h2
`define PROTO_INDIRECT_80  3'h3
`define PROTO_INDIRECT_68  3'h4
`define PROTO_INDIRECT_8B  3'h5
`define PROTO_BURST        3'h6

`endif

/* File: wait_calc.v */
/*
  Combinational wait count for one access from access type,
  register group and the kind of the previous access.
  Assumes inputs are stable when the access starts.
*/
`timescale 1ns/1ps
`include "hostport_defines.vh"
module wait_calc (
  input  wire       is_read,
  input  wire [3:0] group,
  input  wire [1:0] wr_extra,
  input  wire [1:0] rd_extra,
  input  wire       video_first,
  input  wire       prev_valid,
  input  wire       prev_read,
  input  wire       back_to_back,
  output reg  [3:0] wait_cnt
);

  function [3:0] sat_add;
    input [3:0] a;
    input [3:0] b;
    input [3:0] lim;
    reg   [4:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = (s > {1'b0, lim}) ? lim : s[3:0];
    end
  endfunction

  reg [3:0] base;
  reg [3:0] pen;

  always @* begin
    base = 4'h0;
    pen  = 4'h0;
    if (!is_read) begin
      base = sat_add(`WR_WAIT_TYP, {2'b00, wr_extra}, `WR_WAIT_MAX); // [RULE1]
    end else begin
      case (group)
        `GROUP_ISP:   base = `RD_WAIT_ISP;   // [RULE3]
        `GROUP_STILL: base = `RD_WAIT_STILL; // [RULE4]
        `GROUP_VIDEO: base = video_first ? `RD_WAIT_VIDEO_1ST : `RD_WAIT_VIDEO; // [RULE5]
        `GROUP_3D:    base = `RD_WAIT_3D;    // [RULE6]
        default:      base = sat_add(`RD_WAIT_TYP, {2'b00, rd_extra}, `RD_WAIT_MAX); // [RULE2]
      endcase
    end
    if (prev_valid && back_to_back) begin
      case ({prev_read, is_read})
        2'b00:   pen = `PEN_WR_WR;       // [RULE7]
        2'b11:   pen = `PEN_RD_RD;       // [RULE8]
        2'b10:   pen = `PEN_WR_AFTER_RD; // [RULE9]
        default: pen = `PEN_RD_AFTER_WR; // [RULE10]
      endcase
    end
    wait_cnt = base + pen;
  end

endmodule

/* File: async_host_port_wait_control.v */
/*
  Host port wait-state controller of the device: strobe synchronisers,
  wait output, read data drive and protocol trap capture.
  Assumes the host holds select, address and enables stable around
  strobes and keeps strobes low until wait is released.
*/
`timescale 1ns/1ps
`include "hostport_defines.vh"
// Function
// [RULE1] write waits zero, up to three extra
// [RULE2] ordinary read waits two, up to five
// [RULE3] image processor read waits three cycles
// [RULE4] still image codec read waits five
// [RULE5] video read waits five, first seven
// [RULE6] 3D engine read waits seven cycles
// [RULE7] back-to-back writes add one cycle
// [RULE8] back-to-back reads add one cycle
// [RULE9] write after read adds one cycle
// [RULE10] read after write adds three cycles
// [RULE11] waits counted in inner clock periods
// [RULE12] wait low during access, released after
// [RULE13] drive read data, hold, then release
// [RULE14] host sets select and address first
// [RULE15] indirect host qualifies address with valid
// [RULE16] host gives write data after strobe
// [RULE17] host holds strobe until wait released
// [RULE18] bus protocol trapped from pins at reset
module async_host_port_wait_control (
  input  wire        CLOCK,
  input  wire        RESET,
  input  wire        CS_N,
  input  wire        RD_N,
  input  wire        WR_N,
  input  wire [23:0] ADDR,
  input  wire        HOST_ADDR_VALID_N,
  input  wire        HOST_ADDR_BIT_TEN,
  input  wire        HOST_CLK_PIN,
  input  wire [1:0]  CFG,
  input  wire [1:0]  WR_EXTRA,
  input  wire [1:0]  RD_EXTRA,
  input  wire [15:0] RD_DATA_IN,
  input  wire [15:0] DATA_IN,
  output wire [15:0] DATA_OUT,
  output wire        DATA_OE,
  output wire        WAIT_N_OUT,
  output wire        WAIT_OE,
  output wire        WR_STROBE,
  output wire [15:0] WR_DATA,
  output wire [23:0] ACC_ADDR,
  output wire [2:0]  PROTOCOL
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_DONE = 4'b0100;
  localparam ST_HOLD = 4'b1000;

  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg         rd_s1_reg;
  reg         rd_s2_reg;
  reg         wr_s1_reg;
  reg         wr_s2_reg;
  reg  [3:0]  cnt_reg;
  reg  [3:0]  cnt_next;
  reg         is_read_reg;
  reg         prev_valid_reg;
  reg         prev_read_reg;
  reg         gap_reg;
  reg         video_seen_reg;
  reg  [15:0] dout_reg;
  reg         doe_reg;
  reg         wait_oe_reg;
  reg         wstb_reg;
  reg  [15:0] wdata_reg;
  reg  [23:0] addr_reg;
  reg  [2:0]  proto_reg;
  reg         trap_done_reg;
  reg  [23:0] addr_lat_reg;
  wire [3:0]  wait_cnt;
  wire        rd_act;
  wire        wr_act;
  wire        start;
  wire        cur_read;

  // two stage synchronisers; first stage read only by the second [RULE11]
  always @(posedge CLOCK) begin
    if (RESET) begin
      rd_s1_reg <= 1'b0;
      rd_s2_reg <= 1'b0;
      wr_s1_reg <= 1'b0;
      wr_s2_reg <= 1'b0;
    end else begin
      rd_s1_reg <= ~RD_N & ~CS_N;
      rd_s2_reg <= rd_s1_reg;
      wr_s1_reg <= ~WR_N & ~CS_N;
      wr_s2_reg <= wr_s1_reg;
    end
  end

  assign rd_act   = rd_s2_reg;
  assign wr_act   = wr_s2_reg;
  assign start    = (state_reg == ST_IDLE) && (rd_act || wr_act);
  assign cur_read = rd_act;

  // protocol trapped once after reset release [RULE18]
  always @(posedge CLOCK) begin
    if (RESET) begin
      proto_reg     <= `PROTO_DIRECT_80_1;
      trap_done_reg <= 1'b0;
    end else if (!trap_done_reg) begin
      trap_done_reg <= 1'b1;
      case (CFG)
        2'b00:   proto_reg <= HOST_CLK_PIN ? `PROTO_DIRECT_68 :
                              (HOST_ADDR_VALID_N ? `PROTO_DIRECT_80_2 : `PROTO_DIRECT_80_1);
        2'b10:   proto_reg <= HOST_ADDR_BIT_TEN ? `PROTO_INDIRECT_8B :
                              (HOST_CLK_PIN ? `PROTO_INDIRECT_68 : `PROTO_INDIRECT_80);
        2'b11:   proto_reg <= `PROTO_BURST;
        default: proto_reg <= `PROTO_DIRECT_80_1;
      endcase
    end
  end

  // indirect modes latch address while valid and select are low [RULE15]
  always @(posedge CLOCK) begin
    if (RESET) begin
      addr_lat_reg <= 24'h000000;
    end else if (!HOST_ADDR_VALID_N && !CS_N) begin
      addr_lat_reg <= ADDR;
    end
  end

  wire indirect = (proto_reg == `PROTO_INDIRECT_80) || (proto_reg == `PROTO_INDIRECT_68) ||
                  (proto_reg == `PROTO_INDIRECT_8B);
  wire [23:0] eff_addr = indirect ? addr_lat_reg : ADDR; // [RULE14]

  wait_calc u_calc (
    .is_read      (cur_read),
    .group        (eff_addr[`GROUP_MSB:`GROUP_LSB]),
    .wr_extra     (WR_EXTRA),
    .rd_extra     (RD_EXTRA),
    .video_first  (~video_seen_reg),
    .prev_valid   (prev_valid_reg),
    .prev_read    (prev_read_reg),
    .back_to_back (gap_reg),
    .wait_cnt     (wait_cnt)
  );

  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          cnt_next   = wait_cnt;
          state_next = (wait_cnt == 4'h0) ? ST_DONE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        // strobe end releases wait [RULE17]
        if (!rd_act && !wr_act) begin
          state_next = is_read_reg ? ST_HOLD : ST_IDLE;
        end
      end
      ST_HOLD: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= 4'h0;
      is_read_reg    <= 1'b0;
      prev_valid_reg <= 1'b0;
      prev_read_reg  <= 1'b0;
      gap_reg        <= 1'b0;
      video_seen_reg <= 1'b0;
      dout_reg       <= 16'h0000;
      doe_reg        <= 1'b0;
      wait_oe_reg    <= 1'b0;
      wstb_reg       <= 1'b0;
      wdata_reg      <= 16'h0000;
      addr_reg       <= 24'h000000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wstb_reg  <= 1'b0;
      // back-to-back: next access sampled in the first idle cycle after release
      if (state_reg == ST_IDLE) begin
        gap_reg <= 1'b0;
      end
      if (start) begin
        is_read_reg    <= cur_read;
        addr_reg       <= eff_addr;
        wait_oe_reg    <= 1'b1; // [RULE12]
        prev_valid_reg <= 1'b1;
        if (cur_read && eff_addr[`GROUP_MSB:`GROUP_LSB] == `GROUP_VIDEO) begin
          video_seen_reg <= 1'b1; // [RULE5]
        end
      end
      // drive starts with the wait pin, so data never lags the strobe take
      if (cur_read && (start || state_reg != ST_IDLE)) begin
        doe_reg <= 1'b1; // [RULE13]
      end
      // data taken while the strobe is still held low; after release it is gone
      if (state_next == ST_DONE && state_reg != ST_DONE && wr_act) begin
        wdata_reg <= DATA_IN; // [RULE16]
      end
      if (state_next == ST_DONE && is_read_reg) begin
        dout_reg <= RD_DATA_IN; // [RULE13]
      end
      if (state_reg == ST_DONE && state_next != ST_DONE) begin
        wait_oe_reg   <= 1'b0; // [RULE12]
        prev_read_reg <= is_read_reg;
        gap_reg       <= 1'b1; // [RULE7] [RULE8]
        if (!is_read_reg) begin
          wstb_reg  <= 1'b1;
        end
      end
      if (state_reg == ST_HOLD) begin
        doe_reg <= 1'b0; // [RULE13]
      end
    end
  end

  // wait low while counting, high once counted out [RULE12]
  assign WAIT_N_OUT = (state_reg != ST_WAIT);
  assign WAIT_OE    = wait_oe_reg;
  assign DATA_OUT   = dout_reg;
  assign DATA_OE    = doe_reg;
  assign WR_STROBE  = wstb_reg;
  assign WR_DATA    = wdata_reg;
  assign ACC_ADDR   = addr_reg;
  assign PROTOCOL   = proto_reg;

endmodule

/* File: hostport_monitor.sv */
/*
  checker for host port wait and drive timing.
  assumes binding to the top module, ports seen by name.
*/
`timescale 1ns/1ps
`include "hostport_defines.vh"
module hostport_monitor (
  input wire        CLOCK,
  input wire        RESET,
  input wire        CS_N,
  input wire        RD_N,
  input wire        WR_N,
  input wire [23:0] ADDR,
  input wire        WAIT_N_OUT,
  input wire        WAIT_OE,
  input wire        DATA_OE,
  input wire        WR_STROBE,
  input wire [2:0]  PROTOCOL
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_wait_when_driven: assert property (!WAIT_N_OUT |-> WAIT_OE)
    else $error("wait low while pin released");
  a_wait_after_strobe: assert property ($rose(WAIT_OE) |-> $past(!CS_N && (!RD_N || !WR_N)))
    else $error("wait driven without strobe");
  a_wait_release: assert property ($rose(RD_N) && WAIT_OE |-> ##[1:3] !WAIT_OE)
    else $error("wait pin not released");
  a_wait_bounded: assert property (!WAIT_N_OUT |-> ##[0:10] WAIT_N_OUT)
    else $error("wait too long");
  a_read_min_wait: assert property ($rose(WAIT_OE) && !RD_N |-> !WAIT_N_OUT [*2])
    else $error("read wait too short");
  a_read_3d_wait: assert property ($rose(WAIT_OE) && !RD_N && ADDR[`GROUP_MSB:`GROUP_LSB] == `GROUP_3D
    |-> !WAIT_N_OUT [*7]) else $error("3d read wait too short");
  a_read_drive: assert property ($rose(WAIT_OE) && !RD_N |-> DATA_OE)
    else $error("read data not driven");
  a_data_hold: assert property ($fell(DATA_OE) |-> !WAIT_OE && $past(!WAIT_OE))
    else $error("data released too early");
  a_write_pulse: assert property (WR_STROBE |-> $fell(WAIT_OE))
    else $error("write pulse out of place");
  a_trap_stable: assert property ($past(!RESET, 2) && $past(!RESET) |-> $stable(PROTOCOL))
    else $error("protocol changed");
  c_write: cover property ($rose(WR_STROBE));
  c_long_wait: cover property (!WAIT_N_OUT [*7]);
  c_read: cover property ($fell(DATA_OE));
endmodule
bind async_host_port_wait_control hostport_monitor u_hostport_monitor (.*);

/* File: host_model.sv */
/*
  host side model: drives select, address, strobes and write data.
  assumes strobes change at falling clock edges.
*/
`timescale 1ns/1ps
module host_model (
  input  wire         CLOCK,
  input  wire         WAIT_OE,
  input  wire         WAIT_N_OUT,
  input  wire         DATA_OE,
  input  wire [15:0]  DATA_OUT,
  output logic        CS_N,
  output logic        RD_N,
  output logic        WR_N,
  output logic [23:0] ADDR,
  output wire  [15:0] DATA_IN
);
  logic [15:0] drv;
  logic        wr_on;
  wire         wait_pin = WAIT_OE ? WAIT_N_OUT : 1'b1; // pulled up when released
  // released bus shows the inverse, so stale data never matches
  assign DATA_IN = DATA_OE ? DATA_OUT : (wr_on ? drv : ~drv);
  initial begin
    CS_N = 1; RD_N = 1; WR_N = 1; ADDR = 0; drv = 0; wr_on = 0;
  end
  task automatic access(input bit rd, input logic [23:0] a, input logic [15:0] d, input int gap,
                        output int n, output logic [15:0] q);
    int ph;
    int k;
    if (gap > 0) begin
      for (k = 0; k < 20 && WAIT_OE !== 1'b0; k++) @(negedge CLOCK);
      CS_N = 1;
      repeat (gap) @(negedge CLOCK);
      CS_N = 0; ADDR = a; @(negedge CLOCK);
    end else begin
      @(negedge CLOCK); // strobe stays high one cycle between back-to-back accesses
    end
    drv = d; wr_on = !rd; RD_N = !rd; WR_N = rd;
    ph = 0; n = 0;
    for (k = 0; k < 40 && ph < 3; k++) begin
      @(negedge CLOCK);
      if (ph == 2) begin
        if (wait_pin) ph = 3; else n++;
      end
      if (ph == 1 && WAIT_OE) begin
        ph = wait_pin ? 3 : 2; n = !wait_pin;
      end
      if (ph == 0 && !WAIT_OE) ph = 1;
    end
    q = DATA_OUT;
    if (ph < 3) n = 99;
    RD_N = 1; WR_N = 1; wr_on = 0;
  endtask
endmodule

/* File: tb.sv */
/*
  testbench: table of single and back-to-back accesses, then a re-trap.
  assumes the host model drives the port at falling edges.
*/
`timescale 1ns/1ps
`include "hostport_defines.vh"
module tb;
  logic        CLOCK, RESET, HOST_ADDR_VALID_N, HOST_ADDR_BIT_TEN, HOST_CLK_PIN;
  logic [1:0]  CFG, WR_EXTRA, RD_EXTRA;
  logic [15:0] RD_DATA_IN, exp_wd, q;
  logic [23:0] exp_a;
  wire         CS_N, RD_N, WR_N, DATA_OE, WAIT_N_OUT, WAIT_OE, WR_STROBE;
  wire  [15:0] DATA_IN, DATA_OUT, WR_DATA;
  wire  [23:0] ADDR, ACC_ADDR;
  wire  [2:0]  PROTOCOL;
  int          fails = 0, total_checks = 0, n, i;
  typedef struct {bit rd; logic [23:0] a; logic [1:0] wx, rx; int gap, n;} row_t;
  row_t rows [16] = '{'{0, 24'h000010, 0, 0, 3, 0}, '{0, 24'h000010, 2, 0, 3, 2}, '{0, 24'h000010, 3, 0, 3, 3},
    '{1, 24'h000010, 0, 0, 3, 2}, '{1, 24'h000010, 0, 3, 3, 5}, '{1, 24'h000010, 0, 2, 3, 4},
    '{1, 24'h100010, 0, 0, 3, 3}, '{1, 24'h200010, 0, 0, 3, 5}, '{1, 24'h300010, 0, 0, 3, 7},
    '{1, 24'h300010, 0, 0, 3, 5}, '{1, 24'h400010, 0, 0, 3, 7}, '{0, 24'h000010, 0, 0, 3, 0},
    '{0, 24'h000010, 0, 0, 0, 1}, '{1, 24'h000010, 0, 0, 0, 5}, '{1, 24'h000010, 0, 0, 0, 3},
    '{0, 24'h000010, 0, 0, 0, 1}};
  async_host_port_wait_control u_async_host_port_wait_control (.*);
  host_model u_host (.*);
  initial begin
    CLOCK = 0;
    forever #50 CLOCK = ~CLOCK;
  end
  task check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task do_reset(input logic [1:0] cfg, input logic av);
    CFG = cfg; HOST_ADDR_VALID_N = av; RESET = 1;
    repeat (5) @(negedge CLOCK);
    check({DATA_OE, WAIT_OE, WR_STROBE, WAIT_N_OUT}, 4'h1);
    RESET = 0;
    repeat (3) @(negedge CLOCK);
  endtask
  // write pulse carries the captured address and data
  always @(negedge CLOCK) if (WR_STROBE === 1'b1) check({ACC_ADDR, WR_DATA}, {exp_a, exp_wd});
  initial begin
    RESET = 1; HOST_ADDR_BIT_TEN = 0; HOST_CLK_PIN = 0; WR_EXTRA = 0; RD_EXTRA = 0;
    RD_DATA_IN = 0; CFG = 0; HOST_ADDR_VALID_N = 1; exp_a = 0; exp_wd = 0;
    do_reset(2'h0, 1'b1);
    check(PROTOCOL, `PROTO_DIRECT_80_2);
    for (i = 0; i < 16; i++) begin
      WR_EXTRA = rows[i].wx; RD_EXTRA = rows[i].rx; RD_DATA_IN = {8'hA5, i[7:0]};
      exp_a = rows[i].a; exp_wd = rows[i].a[15:0] ^ 16'h5A3C;
      u_host.access(rows[i].rd, rows[i].a, exp_wd, rows[i].gap, n, q);
      check(40'(n), 40'(rows[i].n));
      if (rows[i].rd) check(q, RD_DATA_IN);
      if (n == 99) complete_run();
      $display("test %0d done", i);
    end
    repeat (4) @(negedge CLOCK);
    // second trap: indirect mode, address valid held low, video first-read flag cleared
    do_reset(2'h2, 1'b0);
    check(PROTOCOL, `PROTO_INDIRECT_80);
    u_host.access(1, 24'h300010, 16'h0000, 3, n, q);
    check(40'(n), 40'h7);
    $display("test indirect done");
    complete_run();
  end
endmodule
